// file: rtl/sfpe_flash_seq.sv
// Program, erase and wrap-setup sequencer of a serial NOR flash.
module sfpe_flash_seq #(
  parameter int PAGE_WRITE_CYC       = sfpe_pkg::PAGE_WRITE_CYC,
  parameter int SECTOR_CLEAR_CYC     = sfpe_pkg::SECTOR_CLEAR_CYC,
  parameter int HALF_BLOCK_CLEAR_CYC = sfpe_pkg::HALF_BLOCK_CLEAR_CYC,
  parameter int FULL_BLOCK_CLEAR_CYC = sfpe_pkg::FULL_BLOCK_CLEAR_CYC
) (
  input  wire logic        clk_sys_i,
  input  wire logic        rst_n_i,
  input  wire logic        sclk_i,
  input  wire logic        cs_n_i,
  input  wire logic [3:0]  four_data_lines_i,
  input  wire logic        write_unlock_command_i,
  input  wire logic        four_line_enable_bit_i,
  input  wire logic [4:0]  block_guard_bits_i,
  input  wire logic        rd_load_i,
  input  wire logic [23:0] rd_start_i,
  input  wire logic        rd_step_i,
  output logic      [23:0] rd_addr_o,
  output logic             cycle_in_progress_flag_o,
  output logic             write_latch_flag_o,
  output logic             wrap_disable_bit_o,
  output logic      [1:0]  wrap_length_bits_o,
  output logic             mem_prog_o,
  output logic             mem_erase_o,
  output logic      [1:0]  erase_kind_o,
  output logic      [23:0] mem_addr_o,
  output logic      [7:0]  mem_data_o
);

  localparam int PB = sfpe_pkg::PAGE_BYTES;

  // ==========================================================================
  // Link side: shifts command, address and data on the host's clock.
  // Frame state is never cleared by select, so it stays still for the system
  // side to read once select is high and the link clock has stopped.
  logic          link_arm;
  logic          frame_new_q;
  logic [2:0]    bit_q;
  logic [2:0]    byte_q;
  logic          data_seen_q;
  logic [7:0]    sh_q;
  logic [7:0]    op_q;
  logic [23:0]   addr_q;
  logic [7:0]    col_q;
  logic [7:0]    last_q;
  logic          tgl_q;
  logic [7:0]    buf_q  [PB];
  logic [PB-1:0] mask_q;

  assign link_arm = cs_n_i | ~rst_n_i;

  // Marks the next link edge as the first of a frame.
  always_ff @(posedge sclk_i or posedge link_arm)
  begin
    if (link_arm)
      frame_new_q <= 1'b1;
    else
      frame_new_q <= 1'b0;
  end

  logic [2:0] bit_cur;
  logic [2:0] byte_cur;
  logic       seen_cur;
  logic       quad_phase;
  logic [2:0] bit_next;
  logic       byte_done;
  logic [7:0] sh_next;
  logic       op_done;
  logic       data_wr;

  assign bit_cur    = frame_new_q ? 3'h0 : bit_q;
  assign byte_cur   = frame_new_q ? 3'h0 : byte_q;
  assign seen_cur   = frame_new_q ? 1'b0 : data_seen_q;
  assign quad_phase = (op_q == sfpe_pkg::OP_QUAD_PAGE_WRITE)
                      && (byte_cur == sfpe_pkg::BYTE_DATA);
  assign bit_next   = bit_cur + (quad_phase ? sfpe_pkg::BITS_QUAD : sfpe_pkg::BITS_SINGLE);
  assign byte_done  = (bit_next == 3'h0);
  assign sh_next    = quad_phase ? {sh_q[3:0], four_data_lines_i}
                                 : {sh_q[6:0], four_data_lines_i[0]};
  assign op_done    = byte_done && (byte_cur == sfpe_pkg::BYTE_OPCODE);
  assign data_wr    = byte_done && (byte_cur == sfpe_pkg::BYTE_DATA);

  always_ff @(posedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      bit_q       <= 3'h0;
      byte_q      <= 3'h0;
      data_seen_q <= 1'b0;
      sh_q        <= 8'h00;
      tgl_q       <= 1'b0;
    end
    else
    begin
      bit_q       <= bit_next;
      byte_q      <= (byte_done && byte_cur != sfpe_pkg::BYTE_DATA) ? byte_cur + 3'h1
                                                                     : byte_cur;
      data_seen_q <= seen_cur | data_wr;
      sh_q        <= sh_next;
      tgl_q       <= tgl_q ^ frame_new_q;
    end
  end

  always_ff @(posedge sclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      op_q   <= 8'h00;
      addr_q <= 24'h00_0000;
      col_q  <= 8'h00;
      last_q <= 8'h00;
    end
    else
    begin
      if (op_done)
        op_q <= sh_next;
      if (byte_done && byte_cur >= sfpe_pkg::BYTE_ADDR_FIRST
          && byte_cur <= sfpe_pkg::BYTE_ADDR_LAST)
        addr_q <= {addr_q[15:0], sh_next};
      if (byte_done && byte_cur == sfpe_pkg::BYTE_ADDR_LAST)
        col_q <= sh_next;
      else if (data_wr)
        col_q <= col_q + 8'h01;
      if (data_wr)
        last_q <= sh_next;
    end
  end

  // Page buffer: a later byte for the same column overwrites the earlier one.
  for (genvar i = 0; i < PB; i++)
  begin : g_buf
    always_ff @(posedge sclk_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
      begin
        buf_q[i]  <= 8'h00;
        mask_q[i] <= 1'b0;
      end
      else if (data_wr && col_q == 8'(i))
      begin
        buf_q[i]  <= sh_next;
        mask_q[i] <= 1'b1;
      end
      else if (op_done)
        mask_q[i] <= 1'b0;
    end
  end

  // ==========================================================================
  // Crossing: select and the frame toggle enter the system domain.
  logic cs_s;
  logic tgl_s;
  logic cs_prev_q;
  logic tgl_seen_q;
  logic frame_end;
  logic had_edges;

  sfpe_sync #(
    .WIDTH   (2),
    .RST_VAL (sfpe_pkg::SYNC_RST)
  ) u_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .async_i   ({tgl_q, cs_n_i}),
    .sync_o    ({tgl_s, cs_s})
  );

  assign frame_end = cs_s & ~cs_prev_q;
  assign had_edges = tgl_s != tgl_seen_q;

  // ==========================================================================
  // Command checks, made on the release of select.
  function automatic logic guard_hit(input logic [23:0] a, input logic [4:0] bp);
    logic [23:0] size;
    logic        hit;
    size = (bp[4] ? sfpe_pkg::SECTOR_BYTES : sfpe_pkg::FULL_BYTES) << (bp[2:0] - 3'h1);
    if (bp[2:0] == 3'h0)
      hit = 1'b0;
    else if (bp[2:0] == 3'h7)
      hit = 1'b1;
    else if (bp[3])
      hit = a < size;
    else
      hit = a >= (sfpe_pkg::MEM_BYTES - size);
    return hit;
  endfunction

  sfpe_pkg::sfpe_state_e state_q;
  sfpe_pkg::sfpe_state_e state_d;
  logic        idle;
  logic        lat_q;
  logic        aligned;
  logic        is_prog;
  logic        is_erase;
  logic [23:0] span;
  logic [1:0]  kind;
  logic [23:0] blk_base;
  logic [23:0] page_base;
  logic        prog_ok;
  logic        erase_ok;
  logic        wrap_ok;
  logic [31:0] erase_cyc;

  assign idle      = state_q == sfpe_pkg::ST_IDLE;
  assign aligned   = had_edges && bit_q == 3'h0 && byte_q == sfpe_pkg::BYTE_DATA;
  assign is_prog   = op_q == sfpe_pkg::OP_PAGE_WRITE
                     || (op_q == sfpe_pkg::OP_QUAD_PAGE_WRITE && four_line_enable_bit_i);
  assign is_erase  = op_q == sfpe_pkg::OP_SECTOR_CLEAR || op_q == sfpe_pkg::OP_HALF_BLOCK_CLEAR
                     || op_q == sfpe_pkg::OP_FULL_BLOCK_CLEAR;
  assign span      = op_q == sfpe_pkg::OP_FULL_BLOCK_CLEAR ? sfpe_pkg::FULL_BYTES :
                     op_q == sfpe_pkg::OP_HALF_BLOCK_CLEAR ? sfpe_pkg::HALF_BYTES :
                     sfpe_pkg::SECTOR_BYTES;
  assign kind      = op_q == sfpe_pkg::OP_FULL_BLOCK_CLEAR ? sfpe_pkg::KIND_FULL :
                     op_q == sfpe_pkg::OP_HALF_BLOCK_CLEAR ? sfpe_pkg::KIND_HALF :
                     sfpe_pkg::KIND_SECTOR;
  assign erase_cyc = op_q == sfpe_pkg::OP_FULL_BLOCK_CLEAR ? 32'(FULL_BLOCK_CLEAR_CYC) :
                     op_q == sfpe_pkg::OP_HALF_BLOCK_CLEAR ? 32'(HALF_BLOCK_CLEAR_CYC) :
                     32'(SECTOR_CLEAR_CYC);
  assign blk_base  = addr_q & ~(span - 24'h1);
  assign page_base = {addr_q[23:8], 8'h00};
  assign prog_ok   = frame_end && aligned && data_seen_q && is_prog && lat_q && idle
                     && !guard_hit(page_base, block_guard_bits_i)
                     && !guard_hit(page_base | 24'hFF, block_guard_bits_i);
  assign erase_ok  = frame_end && aligned && !data_seen_q && is_erase && lat_q && idle
                     && !guard_hit(blk_base, block_guard_bits_i)
                     && !guard_hit(blk_base | (span - 24'h1), block_guard_bits_i);
  assign wrap_ok   = frame_end && aligned && data_seen_q && op_q == sfpe_pkg::OP_WRAP_SET;

  // ==========================================================================
  // Self-timed cycle.
  logic [7:0]    idx_q;
  logic [31:0]   wait_q;
  logic [15:0]   page_q;
  logic [7:0]    snap_q [PB];
  logic [PB-1:0] snap_mask_q;
  logic [23:0]   erase_base_q;
  logic          walk_last;

  assign walk_last = idx_q == 8'hFF;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      sfpe_pkg::ST_IDLE:
        if (prog_ok)
          state_d = sfpe_pkg::ST_WALK;
        else if (erase_ok)
          state_d = sfpe_pkg::ST_ERASE;
      sfpe_pkg::ST_WALK:
        if (walk_last)
          state_d = sfpe_pkg::ST_WAIT;
      sfpe_pkg::ST_ERASE:
        state_d = sfpe_pkg::ST_WAIT;
      sfpe_pkg::ST_WAIT:
        if (wait_q == 32'h0)
          state_d = sfpe_pkg::ST_IDLE;
      default:
        state_d = sfpe_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_q    <= sfpe_pkg::ST_IDLE;
      cs_prev_q  <= 1'b1;
      tgl_seen_q <= 1'b0;
      idx_q      <= 8'h00;
      wait_q     <= 32'h0;
    end
    else
    begin
      state_q   <= state_d;
      cs_prev_q <= cs_s;
      if (frame_end)
        tgl_seen_q <= tgl_s;
      idx_q <= (state_q == sfpe_pkg::ST_WALK) ? idx_q + 8'h01 : 8'h00;
      if (prog_ok)
        wait_q <= 32'(PAGE_WRITE_CYC) - 32'h1;
      else if (erase_ok)
        wait_q <= erase_cyc - 32'h1;
      else if (state_q == sfpe_pkg::ST_WAIT && wait_q != 32'h0)
        wait_q <= wait_q - 32'h1;
    end
  end

  // The set from the unlock command wins over the clear at cycle start.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      lat_q <= 1'b0;
    else if (write_unlock_command_i)
      lat_q <= 1'b1;
    else if (prog_ok || erase_ok)
      lat_q <= 1'b0;
  end

  // Snapshot of the captured frame so that a new frame cannot disturb a cycle.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      page_q       <= 16'h0000;
      snap_mask_q  <= '0;
      erase_base_q <= 24'h00_0000;
      erase_kind_o <= sfpe_pkg::KIND_SECTOR;
    end
    else if (prog_ok || erase_ok)
    begin
      page_q       <= addr_q[23:8];
      snap_mask_q  <= mask_q;
      erase_base_q <= blk_base;
      erase_kind_o <= kind;
    end
  end

  for (genvar i = 0; i < PB; i++)
  begin : g_snap
    always_ff @(posedge clk_sys_i or negedge rst_n_i)
    begin
      if (!rst_n_i)
        snap_q[i] <= 8'h00;
      else if (prog_ok)
        snap_q[i] <= buf_q[i];
    end
  end

  // Memory array strobes: one program pulse per received column.
  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mem_prog_o  <= 1'b0;
      mem_erase_o <= 1'b0;
      mem_addr_o  <= 24'h00_0000;
      mem_data_o  <= 8'h00;
    end
    else
    begin
      mem_prog_o  <= state_q == sfpe_pkg::ST_WALK && snap_mask_q[idx_q];
      mem_erase_o <= state_q == sfpe_pkg::ST_ERASE;
      if (state_q == sfpe_pkg::ST_WALK)
      begin
        mem_addr_o <= {page_q, idx_q};
        mem_data_o <= snap_q[idx_q];
      end
      else if (state_q == sfpe_pkg::ST_ERASE)
        mem_addr_o <= erase_base_q;
    end
  end

  assign cycle_in_progress_flag_o = !idle;
  assign write_latch_flag_o       = lat_q;

  // ==========================================================================
  // Wrap settings and the four-line read address walker.
  logic [23:0] wrap_mask;
  logic [23:0] rd_next;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wrap_disable_bit_o <= sfpe_pkg::WRAP_DIS_RST;
      wrap_length_bits_o <= sfpe_pkg::WRAP_LEN_RST;
    end
    else if (wrap_ok)
    begin
      wrap_disable_bit_o <= last_q[sfpe_pkg::WRAP_DIS_POS];
      wrap_length_bits_o <= last_q[sfpe_pkg::WRAP_LEN_POS +: 2];
    end
  end

  assign wrap_mask = (24'h8 << wrap_length_bits_o) - 24'h1;
  assign rd_next   = wrap_disable_bit_o ? rd_addr_o + 24'h1
                     : (rd_addr_o & ~wrap_mask) | ((rd_addr_o + 24'h1) & wrap_mask);

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_addr_o <= 24'h00_0000;
    else if (rd_load_i)
      rd_addr_o <= rd_start_i;
    else if (rd_step_i)
      rd_addr_o <= rd_next;
  end

endmodule

// file: pkg/sfpe_pkg.sv
// Constants and types shared by the serial flash program and erase sequencer.
package sfpe_pkg;

  // ==========================================================================
  // Command codes
  localparam logic [7:0] OP_WRAP_SET          = 8'h77;
  localparam logic [7:0] OP_PAGE_WRITE        = 8'h02;
  localparam logic [7:0] OP_QUAD_PAGE_WRITE   = 8'h32;
  localparam logic [7:0] OP_SECTOR_CLEAR      = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_CLEAR  = 8'h52;
  localparam logic [7:0] OP_FULL_BLOCK_CLEAR  = 8'hD8;

  // ==========================================================================
  // Frame layout
  localparam logic [2:0] BYTE_OPCODE     = 3'h0;
  localparam logic [2:0] BYTE_ADDR_FIRST = 3'h1;
  localparam logic [2:0] BYTE_ADDR_LAST  = 3'h3;
  localparam logic [2:0] BYTE_DATA       = 3'h4;
  localparam logic [2:0] BITS_SINGLE     = 3'h1;
  localparam logic [2:0] BITS_QUAD       = 3'h4;
  localparam int         WRAP_DIS_POS    = 4;
  localparam int         WRAP_LEN_POS    = 5;

  // ==========================================================================
  // Memory geometry
  localparam int          ADDR_W       = 24;
  localparam int          PAGE_BYTES   = 256;
  localparam logic [23:0] MEM_BYTES    = 24'h80_0000;
  localparam logic [23:0] SECTOR_BYTES = 24'h1000;
  localparam logic [23:0] HALF_BYTES   = 24'h8000;
  localparam logic [23:0] FULL_BYTES   = 24'h1_0000;
  localparam logic [1:0]  KIND_SECTOR  = 2'h0;
  localparam logic [1:0]  KIND_HALF    = 2'h1;
  localparam logic [1:0]  KIND_FULL    = 2'h2;

  // ==========================================================================
  // Reset values
  localparam logic       WRAP_DIS_RST = 1'h1;
  localparam logic [1:0] WRAP_LEN_RST = 2'h3;
  localparam logic [1:0] SYNC_RST     = 2'h1;

  // ==========================================================================
  // Cycle times in microseconds and their clock counts
  localparam int CLK_MHZ                = 20;
  localparam int PAGE_WRITE_TIME_US     = 600;
  localparam int SECTOR_CLEAR_TIME_US   = 50000;
  localparam int HALF_BLOCK_CLEAR_TIME_US = 150000;
  localparam int FULL_BLOCK_CLEAR_TIME_US = 200000;
  localparam int PAGE_WRITE_CYC       = PAGE_WRITE_TIME_US * CLK_MHZ;
  localparam int SECTOR_CLEAR_CYC     = SECTOR_CLEAR_TIME_US * CLK_MHZ;
  localparam int HALF_BLOCK_CLEAR_CYC = HALF_BLOCK_CLEAR_TIME_US * CLK_MHZ;
  localparam int FULL_BLOCK_CLEAR_CYC = FULL_BLOCK_CLEAR_TIME_US * CLK_MHZ;

  // ==========================================================================
  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE  = 4'h1,
    ST_WALK  = 4'h2,
    ST_ERASE = 4'h4,
    ST_WAIT  = 4'h8
  } sfpe_state_e;

endpackage

// file: rtl/sfpe_sync.sv
// Two-flip-flop level synchroniser into the system clock domain.
module sfpe_sync #(
  parameter int         WIDTH   = 2,
  parameter logic [1:0] RST_VAL = sfpe_pkg::SYNC_RST
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  always_ff @(posedge clk_sys_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q <= RST_VAL[WIDTH-1:0];
      sync_o <= RST_VAL[WIDTH-1:0];
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// file: bench/sfpe_monitor.sv
// Concurrent checks on the ports of the program and erase sequencer.
module sfpe_monitor (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic        rd_load_i,
  input wire logic [23:0] rd_start_i,
  input wire logic        rd_step_i,
  input wire logic [23:0] rd_addr_o,
  input wire logic        cycle_in_progress_flag_o,
  input wire logic        write_latch_flag_o,
  input wire logic        wrap_disable_bit_o,
  input wire logic        mem_prog_o,
  input wire logic        mem_erase_o,
  input wire logic [1:0]  erase_kind_o,
  input wire logic [23:0] mem_addr_o
);
  timeunit 1ns;
  timeprecision 1ps;
  // ==========================================================================
  // Checks
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);

  a_prog_in_cycle: assert property (mem_prog_o |-> cycle_in_progress_flag_o)
    else $error("program strobe outside a busy cycle");
  a_latch_cleared: assert property ($rose(cycle_in_progress_flag_o) |-> ##[0:2]
    !write_latch_flag_o) else $error("write latch not cleared by the cycle");
  a_needs_latch: assert property ($rose(cycle_in_progress_flag_o) |->
    $past(write_latch_flag_o, 2)) else $error("cycle started without the write latch");
  a_busy_holds: assert property ($rose(cycle_in_progress_flag_o) |->
    cycle_in_progress_flag_o [*8]) else $error("busy flag dropped too early");
  a_erase_align: assert property (mem_erase_o |-> mem_addr_o[11:0] == 12'h000 &&
    (erase_kind_o == 2'h0 || mem_addr_o[14:12] == 3'h0) && (erase_kind_o != 2'h2 ||
    !mem_addr_o[15]) && erase_kind_o != 2'h3) else $error("erase region not aligned");
  a_erase_single: assert property (mem_erase_o |=> !(mem_erase_o || mem_prog_o) [*8])
    else $error("extra strobe after an erase");
  a_prog_page: assert property (mem_prog_o && $past(mem_prog_o) |->
    mem_addr_o[23:8] == $past(mem_addr_o[23:8])) else $error("program left its page");
  a_wrap_step: assert property (rd_step_i && !rd_load_i && !wrap_disable_bit_o |=>
    rd_addr_o[23:6] == $past(rd_addr_o[23:6])) else $error("wrapped read left its section");
  a_linear_step: assert property (rd_step_i && !rd_load_i && wrap_disable_bit_o |=>
    rd_addr_o == $past(rd_addr_o) + 24'h00_0001) else $error("linear read did not advance");
  a_load_addr: assert property (rd_load_i |=> rd_addr_o == $past(rd_start_i))
    else $error("read start not loaded");
endmodule

bind sfpe_flash_seq sfpe_monitor mon (
  .clk_sys_i, .rst_n_i, .rd_load_i, .rd_start_i, .rd_step_i, .rd_addr_o,
  .cycle_in_progress_flag_o, .write_latch_flag_o, .wrap_disable_bit_o, .mem_prog_o,
  .mem_erase_o, .erase_kind_o, .mem_addr_o
);

// file: bench/sfpe_host_model.sv
// Host controller model that frames commands onto select, link clock and data lines.
module sfpe_host_model (
  output logic       sclk_o,
  output logic       cs_n_o,
  output logic [3:0] lines_o
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [7:0] tx_q[$];

  initial
  begin
    sclk_o  = 1'b0;
    cs_n_o  = 1'b1;
    lines_o = 4'h5;
  end

  task automatic shift(input logic [3:0] v);
    lines_o = v;
    #15 sclk_o = 1'b1;
    #15 sclk_o = 1'b0;
  endtask

  task automatic put_bits(input logic [31:0] v, input int n);
    for (int i = n - 1; i >= 0; i--)
      shift({~{3{v[i]}}, v[i]});
  endtask

  // Extra bits leave a torn byte at the end of the frame.
  task automatic frame(input logic [7:0] op, input logic [23:0] addr, input logic quad,
                       input int extra);
    logic [7:0] b;
    cs_n_o = 1'b0;
    #15;
    put_bits({24'h00_0000, op}, 8);
    put_bits({8'h00, addr}, 24);
    while (tx_q.size() > 0)
    begin
      b = tx_q.pop_front();
      if (quad)
      begin
        shift(b[7:4]);
        shift(b[3:0]);
      end
      else
        put_bits({24'h00_0000, b}, 8);
    end
    put_bits(32'h0000_0000, extra);
    #15 cs_n_o = 1'b1;
    lines_o = ~lines_o;
    #300;
  endtask
endmodule

// file: bench/serial_flash_program_erase_bench.sv
// Self-checking bench for the serial flash program and erase sequencer.
module serial_flash_program_erase_bench;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk_sys_i;
  logic        rst_n_i;
  logic        sclk;
  logic        cs_n;
  logic [3:0]  lines;
  logic        unlock;
  logic        four_en;
  logic [4:0]  guard;
  logic        rd_load;
  logic [23:0] rd_start;
  logic        rd_step;
  logic [23:0] rd_addr;
  logic        busy;
  logic        latch;
  logic        wrap_dis;
  logic [1:0]  wrap_len;
  logic        mem_prog;
  logic        mem_erase;
  logic [1:0]  kind;
  logic [23:0] mem_addr;
  logic [7:0]  mem_data;
  logic [34:0] exp_q[$];
  logic [7:0]  col_d[256];
  logic        col_v[256];
  logic [7:0]  ers_op[3] = '{8'h20, 8'h52, 8'hD8};
  logic [23:0] ers_base[3] = '{24'h12_B000, 24'h12_8000, 24'h12_0000};
  logic [31:0] seed = 32'h0000_1FBC;
  int          err_count = 0;
  int          num_checks = 0;
  int          cycles = 0;

  sfpe_flash_seq #(
    .PAGE_WRITE_CYC       (20),
    .SECTOR_CLEAR_CYC     (40),
    .HALF_BLOCK_CLEAR_CYC (60),
    .FULL_BLOCK_CLEAR_CYC (80)
  ) dut (
    .clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .four_data_lines_i(lines), .write_unlock_command_i(unlock),
    .four_line_enable_bit_i(four_en), .block_guard_bits_i(guard), .rd_load_i(rd_load),
    .rd_start_i(rd_start), .rd_step_i(rd_step), .rd_addr_o(rd_addr),
    .cycle_in_progress_flag_o(busy), .write_latch_flag_o(latch),
    .wrap_disable_bit_o(wrap_dis), .wrap_length_bits_o(wrap_len), .mem_prog_o(mem_prog),
    .mem_erase_o(mem_erase), .erase_kind_o(kind), .mem_addr_o(mem_addr),
    .mem_data_o(mem_data)
  );

  sfpe_host_model host (.sclk_o(sclk), .cs_n_o(cs_n), .lines_o(lines));

  // ==========================================================================
  // Clock, timeout and result watcher
  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  always @(posedge clk_sys_i)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      err_count++;
      finish_test();
    end
  end

  always @(negedge clk_sys_i)
    if (mem_prog || mem_erase)
    begin
      if (exp_q.size() == 0)
        check({mem_erase, kind, mem_addr, mem_data}, ~{mem_erase, kind, mem_addr, mem_data});
      else
        check({mem_erase, mem_erase ? kind : 2'h0, mem_addr, mem_erase ? 8'h00 : mem_data},
              exp_q.pop_front());
    end

  // ==========================================================================
  // Tasks
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [34:0] seen, input logic [34:0] want);
    num_checks++;
    if (seen !== want)
    begin
      err_count++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, want);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask

  task automatic open_latch();
    unlock = 1'b1;
    tick(1);
    unlock = 1'b0;
    tick(1);
  endtask

  task automatic run(input logic [7:0] op, input logic [23:0] a, input int n, input int extra,
                     input logic take);
    logic [7:0] b;
    logic [7:0] c;
    for (int i = 0; i < 256; i++)
      col_v[i] = 1'b0;
    for (int i = 0; i < n; i++)
    begin
      b = 8'(rnd());
      c = a[7:0] + 8'(i);
      col_d[c] = b;
      col_v[c] = 1'b1;
      host.tx_q.push_back(b);
    end
    for (int i = 0; i < 256; i++)
      if (take && col_v[i])
        exp_q.push_back({3'h0, a[23:8], 8'(i), col_d[i]});
    host.frame(op, a, op == sfpe_pkg::OP_QUAD_PAGE_WRITE, extra);
    tick(1);
    if (take)
    begin
      check(35'(busy), 35'h1);
      check(35'(latch), 35'h0);
      for (int i = 0; i < 3000 && busy !== 1'b0; i++)
        tick(1);
    end
    else
      tick(10);
    check(35'(busy), 35'h0);
    check(35'(exp_q.size()), 35'h0);
    $display("test of command %h at %h done", op, a);
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // ==========================================================================
  // Main sequence
  initial
  begin
    rst_n_i  = 1'b0;
    unlock   = 1'b0;
    four_en  = 1'b0;
    guard    = 5'h00;
    rd_load  = 1'b0;
    rd_start = 24'h00_0000;
    rd_step  = 1'b0;
    tick(2);
    rst_n_i = 1'b1;
    tick(1);
    check({wrap_len, wrap_dis, busy, latch}, 35'h1C);
    run(sfpe_pkg::OP_PAGE_WRITE, 24'h00_0210, 2, 0, 1'b0);
    open_latch();
    run(sfpe_pkg::OP_PAGE_WRITE, 24'h00_03FE, 3, 0, 1'b1);
    open_latch();
    run(sfpe_pkg::OP_PAGE_WRITE, 24'h00_0500, 258, 0, 1'b1);
    open_latch();
    run(sfpe_pkg::OP_QUAD_PAGE_WRITE, 24'h00_0640, 2, 0, 1'b0);
    four_en = 1'b1;
    run(sfpe_pkg::OP_QUAD_PAGE_WRITE, 24'h00_0640, 2, 0, 1'b1);
    open_latch();
    run(sfpe_pkg::OP_PAGE_WRITE, 24'h00_0700, 2, 3, 1'b0);
    run(sfpe_pkg::OP_SECTOR_CLEAR, 24'h12_B456, 1, 0, 1'b0);
    run(sfpe_pkg::OP_SECTOR_CLEAR, 24'h12_B456, 0, 5, 1'b0);
    for (int k = 0; k < 3; k++)
    begin
      open_latch();
      exp_q.push_back({1'b1, 2'(k), ers_base[k], 8'h00});
      run(ers_op[k], 24'h12_B456, 0, 0, 1'b1);
    end
    guard = 5'h01;
    open_latch();
    run(sfpe_pkg::OP_SECTOR_CLEAR, 24'h7F_1234, 0, 0, 1'b0);
    run(sfpe_pkg::OP_PAGE_WRITE, 24'h7F_FF00, 1, 0, 1'b0);
    guard = 5'h00;
    host.tx_q.push_back(8'h00);
    host.frame(sfpe_pkg::OP_WRAP_SET, 24'(rnd()), 1'b0, 0);
    tick(1);
    check({wrap_dis, wrap_len}, 35'h0);
    rd_start = {16'(rnd()), 8'h06};
    rd_load = 1'b1;
    tick(1);
    rd_load = 1'b0;
    rd_step = 1'b1;
    tick(1);
    check(35'(rd_addr), 35'({rd_start[23:8], 8'h07}));
    tick(1);
    check(35'(rd_addr), 35'({rd_start[23:8], 8'h00}));
    rd_step = 1'b0;
    host.tx_q.push_back(8'h70);
    host.frame(sfpe_pkg::OP_WRAP_SET, 24'(rnd()), 1'b0, 0);
    tick(1);
    check({wrap_dis, wrap_len}, 35'h7);
    rd_step = 1'b1;
    tick(1);
    rd_step = 1'b0;
    check(35'(rd_addr), 35'({rd_start[23:8], 8'h01}));
    $display("test of wrap setup done");
    finish_test();
  end
endmodule
